/* File: rtl/dps_params.svh */
// constants and register map for the drive protection supervisor
`ifndef DPS_PARAMS_SVH
`define DPS_PARAMS_SVH

// ==========================================================
// register byte offsets
`define DPS_OFS_MASK 12'h000
`define DPS_OFS_THR_RATED 12'h004
`define DPS_OFS_THR_MID 12'h008
`define DPS_OFS_THR_LOW 12'h00C
`define DPS_OFS_ALARM_LVL 12'h010
`define DPS_OFS_LEVEL 12'h014
`define DPS_OFS_STATUS 12'h018
`define DPS_OFS_CONFIG 12'h01C
`define DPS_OFS_RATINGS 12'h020
`define DPS_OFS_PS_LEVEL 12'h024

// ==========================================================
// reset values and fields
`define DPS_RST_MASK 16'h0003
`define DPS_RST_ALARM_LVL 16'h0055
`define DPS_ALARM_LVL_MIN 16'h0046
`define DPS_ALARM_LVL_MAX 16'h0064
`define DPS_THR_MAX 16'h07D0
`define DPS_MASK_GROUND 0
`define DPS_MASK_PSTAGE 1
`define DPS_MASK_BIT4 4
`define DPS_AIN_PTC_OPT 4'h4
`define DPS_DIN_PTC_FN 6'h1D
`define DPS_MOD_ALARM_MARGIN 8'h05
`define DPS_REDUCED_FSW_HZ 16'h09C4
// analog sensor limits in millivolts
`define DPS_AIN_HIGH_MV 16'h238C
`define DPS_AIN_LOW_MV 16'h0514

// ==========================================================
// timing: one integrator tick per millisecond
`define DPS_TICK_US 1000
`define DPS_CLK_MHZ 25
`define DPS_TICK_CYCLES (`DPS_TICK_US * `DPS_CLK_MHZ)
`define DPS_MOTOR_TRIP_MS 60000
`define DPS_PS_TRIP_MS 3000

`endif

/* File: rtl/dps_pkg.sv */
// types shared by the drive protection supervisor
package dps_pkg;

    // ==========================================================
    // measurements in
    typedef struct packed {
        logic [15:0] current_da;
        logic [15:0] speed_permil;
        logic [15:0] ain_mv;
        logic [7:0] module_temp_c;
    } dps_meas_t;

    // ==========================================================
    // protection outputs
    typedef struct packed {
        logic motor_overload_fault;
        logic motor_overload_alarm;
        logic power_stage_overload_fault;
        logic power_stage_overload_alarm;
        logic motor_overtemp_fault;
        logic power_module_overtemp_fault;
        logic power_module_overtemp_alarm;
        logic ground_fault;
        logic maskable_fault_bit4;
    } dps_flags_t;

    typedef enum logic [1:0] {
        DPS_SPD_LOW = 2'b00,
        DPS_SPD_MID = 2'b01,
        DPS_SPD_RATED = 2'b11
    } dps_speed_band_t;

endpackage

/* File: rtl/dps_supervisor.sv */
// drive protection supervisor: overload integrators, thermal checks, APB registers
`timescale 1ns/1ps
`include "dps_params.svh"

module dps_supervisor #(
    parameter int TICK_CYCLES = `DPS_TICK_CYCLES,
    parameter int MOTOR_TRIP_MS = `DPS_MOTOR_TRIP_MS,
    parameter int PS_TRIP_MS = `DPS_PS_TRIP_MS,
    parameter logic [7:0] MODULE_FAULT_C = 8'h50,
    parameter logic [15:0] NOMINAL_DA = 16'h0064
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // measurements, same clock domain
    input wire dps_pkg::dps_meas_t meas_in,
    // raw pins from outside
    input wire logic ground_trip_pin_in,
    input wire logic bit4_trip_pin_in,
    input wire logic [7:0] din_pins_in,
    // retained integrator value
    input wire logic [15:0] retained_level_in,
    output logic [15:0] retained_level_out,
    // protection results
    output dps_pkg::dps_flags_t flags_out,
    output logic [15:0] switching_frequency_out
);

    // ==========================================================
    // parameter checks
    initial
    begin
        if (TICK_CYCLES < 1 || MOTOR_TRIP_MS < 1 || PS_TRIP_MS < 1)
            $error("counts must be positive");
        if (MODULE_FAULT_C < 8'h50 || MODULE_FAULT_C > 8'h7B)
            $error("module fault level out of range");
    end

    // integrator full scale: 100 percent of trip; per tick it gains
    // excess*(LIMIT/trip_ms)/half_threshold, so 150 percent trips on time
    localparam logic [31:0] LIMIT = 32'h0100_0000;
    localparam logic [31:0] M_STEP = LIMIT / 32'(MOTOR_TRIP_MS);
    localparam logic [31:0] P_STEP = LIMIT / 32'(PS_TRIP_MS);

    // ==========================================================
    // pin synchronisers
    logic [9:0] sync1_reg;
    logic [9:0] sync2_reg;
    always_ff @(posedge clk_in)
    begin
        sync1_reg <= {ground_trip_pin_in, bit4_trip_pin_in, din_pins_in};
        sync2_reg <= sync1_reg;
    end

    // ==========================================================
    // registers
    logic [15:0] mask_reg;
    logic [15:0] thr_rated_reg;
    logic [15:0] thr_mid_reg;
    logic [15:0] thr_low_reg;
    logic [15:0] alarm_lvl_reg;
    logic [15:0] config_reg;
    logic [15:0] inv_rated_reg;
    logic [31:0] m_int_reg;
    logic [31:0] p_int_reg;
    logic [TICK_CYCLES > 1 ? $clog2(TICK_CYCLES) - 1 : 0:0] tick_cnt_reg;
    logic loaded_reg;
    logic [31:0] prdata_reg;
    dps_pkg::dps_flags_t flags_reg;

    wire apb_wr = psel_in & penable_in & pwrite_in;
    wire apb_rd = psel_in & penable_in & ~pwrite_in;
    wire tick = (32'(tick_cnt_reg) == 32'(TICK_CYCLES - 1));

    // config: [3:0] analog option, [9:4] digital function,
    // [12:10] digital input number, [13] disable frequency cut, [15:14] analog input
    wire [3:0] ain_opt = config_reg[3:0];
    wire [5:0] din_fn = config_reg[9:4];
    wire [2:0] din_sel = config_reg[12:10];
    wire fsw_cut_off = config_reg[13];

    function automatic logic [15:0] clamp_thr(input logic [15:0] v);
        clamp_thr = (v > `DPS_THR_MAX) ? `DPS_THR_MAX : v;
    endfunction

    function automatic logic [31:0] level_pct(input logic [31:0] v);
        level_pct = (v * 32'd100) >> 24;
    endfunction

    // ==========================================================
    // threshold selection by speed
    dps_pkg::dps_speed_band_t band;
    assign band = (meas_in.speed_permil < 16'd50) ? dps_pkg::DPS_SPD_LOW :
        (meas_in.speed_permil <= 16'd500) ? dps_pkg::DPS_SPD_MID :
        dps_pkg::DPS_SPD_RATED;
    logic [15:0] thr_sel;
    always_comb
    begin
        unique case (band)
            dps_pkg::DPS_SPD_LOW: thr_sel = thr_low_reg;
            dps_pkg::DPS_SPD_MID: thr_sel = thr_mid_reg;
            dps_pkg::DPS_SPD_RATED: thr_sel = thr_rated_reg;
            default: thr_sel = thr_rated_reg;
        endcase
    end

    // ==========================================================
    // motor integrator: gain above threshold, cool below
    wire m_over = meas_in.current_da > thr_sel;
    wire [31:0] m_excess = 32'(meas_in.current_da - thr_sel);
    wire [31:0] m_half = {17'h0, thr_sel[15:1]} | 32'h1;
    wire [47:0] m_gain = 48'(m_excess) * 48'(M_STEP) / 48'(m_half);
    wire [47:0] m_sum = 48'(m_int_reg) + m_gain;
    wire [31:0] m_up = (m_sum >= 48'(LIMIT)) ? LIMIT : m_sum[31:0];
    wire [31:0] m_down = (m_int_reg > M_STEP) ? m_int_reg - M_STEP : 32'h0;
    wire [31:0] m_next = m_over ? m_up : m_down;

    // power stage: 150 percent of rating starts, 200 percent trips in PS_TRIP_MS
    wire [16:0] p_thr = 17'(inv_rated_reg) + 17'(inv_rated_reg[15:1]);
    wire p_over = 17'(meas_in.current_da) > p_thr;
    wire [31:0] p_excess = 32'(17'(meas_in.current_da) - p_thr);
    wire [31:0] p_half = {17'h0, inv_rated_reg[15:1]} | 32'h1;
    wire [47:0] p_gain = 48'(p_excess) * 48'(P_STEP) / 48'(p_half);
    wire [47:0] p_sum = 48'(p_int_reg) + p_gain;
    wire [31:0] p_up = (p_sum >= 48'(LIMIT)) ? LIMIT : p_sum[31:0];
    wire [31:0] p_down = (p_int_reg > P_STEP) ? p_int_reg - P_STEP : 32'h0;
    wire [31:0] p_next = p_over ? p_up : p_down;

    wire [15:0] m_pct = 16'(level_pct(m_int_reg));
    wire [15:0] p_pct = 16'(level_pct(p_int_reg));

    // ==========================================================
    // alarms and faults
    wire alarm_on = alarm_lvl_reg < `DPS_ALARM_LVL_MAX;
    wire m_alarm = alarm_on & (m_pct > alarm_lvl_reg);
    wire m_fault = m_int_reg >= LIMIT;
    wire ps_en = mask_reg[`DPS_MASK_PSTAGE];
    wire p_alarm = ps_en & alarm_on & (p_pct > alarm_lvl_reg);
    wire p_fault = ps_en & (p_int_reg >= LIMIT);

    // analog sensor with option 4 alone; config bits [15:14] are not checked
    wire ain_ptc = (ain_opt == `DPS_AIN_PTC_OPT);
    wire ain_bad = (meas_in.ain_mv > `DPS_AIN_HIGH_MV) |
        (meas_in.ain_mv < `DPS_AIN_LOW_MV);
    // digital sensor: low pin means high resistance; input 1 is the frequency input
    wire din_ptc = (din_fn == `DPS_DIN_PTC_FN) & (din_sel != 3'd1);
    wire din_bad = ~sync2_reg[din_sel];
    wire mot_ot = (ain_ptc & ain_bad) | (din_ptc & din_bad);

    wire mod_fault = meas_in.module_temp_c >= MODULE_FAULT_C;
    wire mod_alarm = meas_in.module_temp_c >= MODULE_FAULT_C - `DPS_MOD_ALARM_MARGIN;

    // ==========================================================
    // apb register writes
    wire wr_mask = apb_wr & (paddr_in == `DPS_OFS_MASK);
    wire wr_rated = apb_wr & (paddr_in == `DPS_OFS_THR_RATED);
    wire wr_mid = apb_wr & (paddr_in == `DPS_OFS_THR_MID);
    wire wr_low = apb_wr & (paddr_in == `DPS_OFS_THR_LOW);
    wire wr_alarm = apb_wr & (paddr_in == `DPS_OFS_ALARM_LVL);
    wire wr_cfg = apb_wr & (paddr_in == `DPS_OFS_CONFIG);
    wire wr_rat = apb_wr & (paddr_in == `DPS_OFS_RATINGS);
    wire [15:0] wlo = pwdata_in[15:0];
    wire [15:0] alarm_wr = (wlo < `DPS_ALARM_LVL_MIN) ? `DPS_ALARM_LVL_MIN :
        (wlo > `DPS_ALARM_LVL_MAX) ? `DPS_ALARM_LVL_MAX : wlo;

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            mask_reg <= `DPS_RST_MASK;
            thr_rated_reg <= 16'((32'(NOMINAL_DA) * 32'd11) / 32'd10);
            thr_mid_reg <= NOMINAL_DA;
            thr_low_reg <= 16'((32'(NOMINAL_DA) * 32'd8) / 32'd10);
            alarm_lvl_reg <= `DPS_RST_ALARM_LVL;
            config_reg <= 16'h0000;
            inv_rated_reg <= NOMINAL_DA;
        end
        else
        begin
            if (wr_mask)
                mask_reg <= wlo & 16'h0013;
            if (wr_rated)
                thr_rated_reg <= clamp_thr(wlo);
            if (wr_mid)
                thr_mid_reg <= clamp_thr(wlo);
            if (wr_low)
                thr_low_reg <= clamp_thr(wlo);
            if (wr_alarm)
                alarm_lvl_reg <= alarm_wr;
            if (wr_cfg)
                config_reg <= wlo;
            if (wr_rat)
                inv_rated_reg <= wlo;
        end
    end

    // ==========================================================
    // integrators; the retained level is loaded at the first edge after reset
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            m_int_reg <= 32'h0;
            p_int_reg <= 32'h0;
            tick_cnt_reg <= '0;
            loaded_reg <= 1'b0;
        end
        else if (!loaded_reg)
        begin
            loaded_reg <= 1'b1;
            m_int_reg <= (retained_level_in >= 16'd100) ? LIMIT :
                32'(((32'(retained_level_in) << 24) + 32'd99) / 32'd100);
        end
        else
        begin
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
            if (tick)
            begin
                m_int_reg <= m_next;
                p_int_reg <= p_next;
            end
        end
    end

    // ==========================================================
    // outputs
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            flags_reg <= '0;
            retained_level_out <= 16'h0;
            switching_frequency_out <= 16'h0;
        end
        else
        begin
            flags_reg.motor_overload_fault <= m_fault;
            flags_reg.motor_overload_alarm <= m_alarm;
            flags_reg.power_stage_overload_fault <= p_fault;
            flags_reg.power_stage_overload_alarm <= p_alarm;
            flags_reg.motor_overtemp_fault <= mot_ot;
            flags_reg.power_module_overtemp_fault <= mod_fault;
            flags_reg.power_module_overtemp_alarm <= mod_alarm;
            flags_reg.ground_fault <= mask_reg[`DPS_MASK_GROUND] & sync2_reg[9];
            flags_reg.maskable_fault_bit4 <= mask_reg[`DPS_MASK_BIT4] & sync2_reg[8];
            retained_level_out <= m_pct;
            // zero means no cut; otherwise the reduced frequency in hertz
            switching_frequency_out <= (mod_alarm & ~fsw_cut_off) ?
                `DPS_REDUCED_FSW_HZ : 16'h0;
        end
    end
    assign flags_out = flags_reg;

    // ==========================================================
    // apb read; zero wait, unmapped reads zero with error
    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb
    begin
        rd_hit = 1'b1;
        unique case (paddr_in)
            `DPS_OFS_MASK: rd_mux = {16'h0, mask_reg};
            `DPS_OFS_THR_RATED: rd_mux = {16'h0, thr_rated_reg};
            `DPS_OFS_THR_MID: rd_mux = {16'h0, thr_mid_reg};
            `DPS_OFS_THR_LOW: rd_mux = {16'h0, thr_low_reg};
            `DPS_OFS_ALARM_LVL: rd_mux = {16'h0, alarm_lvl_reg};
            `DPS_OFS_LEVEL: rd_mux = {16'h0, m_pct};
            `DPS_OFS_STATUS: rd_mux = {23'h0, flags_reg};
            `DPS_OFS_CONFIG: rd_mux = {16'h0, config_reg};
            `DPS_OFS_RATINGS: rd_mux = {16'h0, inv_rated_reg};
            `DPS_OFS_PS_LEVEL: rd_mux = {16'h0, p_pct};
            default:
            begin
                rd_mux = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end
    assign prdata_out = apb_rd ? rd_mux : 32'h0;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~rd_hit;

endmodule

/* File: tb/dps_supervisor_chk.sv */
// port-level assertions for the drive protection supervisor
`timescale 1ns/1ps

module dps_supervisor_chk #(
    parameter logic [7:0] MODULE_FAULT_C = 8'h50
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // apb slave side
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] prdata_out,
    input wire logic pslverr_out,
    // protection side
    input wire dps_pkg::dps_meas_t meas_in,
    input wire logic ground_trip_pin_in,
    input wire logic [15:0] retained_level_out,
    input wire dps_pkg::dps_flags_t flags_out,
    input wire logic [15:0] switching_frequency_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    // ==========================================================
    // assertions
    a_mod_alarm: assert property (!$past(srst_in) |->
        flags_out.power_module_overtemp_alarm ==
        ($past(meas_in.module_temp_c) >= MODULE_FAULT_C - 8'h05)) else $error("module alarm level");
    a_mod_fault: assert property (!$past(srst_in) |->
        flags_out.power_module_overtemp_fault ==
        ($past(meas_in.module_temp_c) >= MODULE_FAULT_C)) else $error("module fault level");
    a_fsw_cut: assert property (switching_frequency_out != 16'h0000 |->
        switching_frequency_out == 16'h09C4 && (flags_out.power_module_overtemp_alarm ||
        $past(flags_out.power_module_overtemp_alarm))) else $error("switching cut value");
    a_rdata_idle: assert property (!(psel_in && penable_in && !pwrite_in) |->
        prdata_out == 32'h0) else $error("read data outside access");
    a_err_phase: assert property (pslverr_out |-> psel_in && penable_in)
        else $error("error outside access");
    a_level_cap: assert property (retained_level_out <= 16'h0064)
        else $error("level above limit");
    a_alarm_above: assert property (flags_out.motor_overload_alarm |->
        retained_level_out > 16'h0046 || $past(retained_level_out) > 16'h0046)
        else $error("alarm below minimum level");
    a_ground_lag: assert property ($rose(flags_out.ground_fault) |->
        $past(ground_trip_pin_in, 3)) else $error("ground fault without pin");

    // ==========================================================
    // coverage
    c_motor_trip: cover property ($rose(flags_out.motor_overload_fault));
    c_ps_trip: cover property ($rose(flags_out.power_stage_overload_fault));
    c_fsw_cut: cover property ($rose(switching_frequency_out == 16'h09C4));
endmodule

/* File: tb/dps_plant.sv */
// sensor front end model feeding the supervisor measurements
`timescale 1ns/1ps

module dps_plant (
    // clock
    input wire logic clk_in,
    // sensed quantities
    input wire logic [15:0] cur_in,
    input wire logic [15:0] spd_in,
    input wire logic [15:0] ain_in,
    input wire logic [7:0] temp_in,
    // sampled measurement word
    output dps_pkg::dps_meas_t meas_out
);
    // converters deliver one registered sample per clock, so results lag one edge more
    always_ff @(posedge clk_in)
        meas_out <= {cur_in, spd_in, ain_in, temp_in};
endmodule

/* File: tb/tb_drive_protection_supervisor.sv */
// self-checking bench for the drive protection supervisor
`timescale 1ns/1ps

module tb_drive_protection_supervisor;
    localparam int TK = 4;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, pready_out, pslverr_out;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out;
    logic ground_in = 1'b0, bit4_in = 1'b0, alarm_seen = 1'b0;
    logic [7:0] din_in = 8'hFF, temp_in = 8'h19;
    logic [7:0] tt[4] = '{8'h4A, 8'h4B, 8'h4F, 8'h50};
    logic [15:0] ret_in = 16'h0, ret_out, fsw_out, cur_in = 16'h0, spd_in = 16'h0;
    logic [15:0] ain_in = 16'h1388, lfsr = 16'hBB10, av;
    logic [15:0] avt[4] = '{16'h238D, 16'h0513, 16'h238C, 16'h0514};
    dps_pkg::dps_meas_t meas;
    dps_pkg::dps_flags_t flags_out;
    logic [32:0] expq[$];
    int n_mismatch = 0, total_checks = 0;

    always #20 clk_in = ~clk_in;

    dps_plant plant (.clk_in, .cur_in, .spd_in, .ain_in, .temp_in, .meas_out(meas));
    dps_supervisor #(.TICK_CYCLES(TK), .MOTOR_TRIP_MS(60), .PS_TRIP_MS(3)) dut (
        .clk_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .meas_in(meas), .ground_trip_pin_in(ground_in),
        .bit4_trip_pin_in(bit4_in), .din_pins_in(din_in), .retained_level_in(ret_in),
        .retained_level_out(ret_out), .flags_out, .switching_frequency_out(fsw_out));

    // ==========================================================
    // helpers
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // read data is noted here and compared by the monitor at the completing edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        @(posedge clk_in);
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
        if (!w) expq.push_back(e);
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready_out !== 1'b1 && n < 50);
        if (pready_out !== 1'b1)
            n_mismatch++;
        {psel_in, penable_in} <= 2'b00;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic do_reset(input logic [15:0] r);
        srst_in <= 1'b1;
        ret_in <= r;
        repeat (4) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
    endtask

    // counts cycles until a flag rises; a late or early rise is a mismatch
    task automatic trip(input int b, input int lo, input int hi);
        int n;
        n = 0;
        while (flags_out[b] !== 1'b1 && n < hi)
        begin
            @(posedge clk_in);
            n++;
        end
        chk(33'(n >= lo && n < hi), 33'h1);
    endtask

    always @(posedge clk_in)
        if (psel_in && penable_in && pready_out && !pwrite_in && expq.size() > 0)
            chk({pslverr_out, prdata_out}, expq.pop_front());

    // cleared by every reset so each overload run starts without a stale alarm
    always @(posedge clk_in)
        if (srst_in)
            alarm_seen <= 1'b0;
        else if (flags_out.motor_overload_alarm === 1'b1)
            alarm_seen <= 1'b1;

    // ==========================================================
    // scenarios
    initial
    begin
        do_reset(16'h0000);
        rd(12'h000, 32'h0003);
        rd(12'h004, 32'h006E);
        rd(12'h008, 32'h0064);
        rd(12'h00C, 32'h0050);
        rd(12'h010, 32'h0055);
        rd(12'h014, 32'h0000);
        apb(1'b0, 12'h0FC, 32'h0, {1'b1, 32'h0});
        wr(12'h000, 32'hFFFF);
        rd(12'h000, 32'h0013);
        wr(12'h004, 32'hFFFF);
        rd(12'h004, 32'h07D0);
        wr(12'h004, 32'h006E);
        wr(12'h010, 32'h0010);
        rd(12'h010, 32'h0046);
        wr(12'h014, 32'h0030);
        rd(12'h014, 32'h0000);
        ground_in <= 1'b1;
        bit4_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        rd(12'h018, 32'h0003);
        wr(12'h000, 32'h0003);
        rd(12'h018, 32'h0002);
        ground_in <= 1'b0;
        bit4_in <= 1'b0;
        $display("test registers done");
        foreach (tt[i])
        begin
            temp_in <= tt[i];
            repeat (4) @(posedge clk_in);
            rd(12'h018, {28'h0, tt[i] >= 8'h50, tt[i] >= 8'h4B, 2'b00});
            chk({17'h0, fsw_out}, tt[i] >= 8'h4B ? 33'h09C4 : 33'h0);
        end
        wr(12'h01C, 32'h2000);
        repeat (3) @(posedge clk_in);
        chk({17'h0, fsw_out}, 33'h0);
        temp_in <= 8'h19;
        wr(12'h01C, 32'h0004);
        for (int i = 0; i < 7; i++)
        begin
            lfsr = nxt(lfsr);
            av = i < 4 ? avt[i] : 16'h0578 + lfsr % 16'h1D4C;
            ain_in <= av;
            repeat (3) @(posedge clk_in);
            rd(12'h018, {27'h0, i < 2, 4'h0});
        end
        for (int i = 0; i < 2; i++)
        begin
            wr(12'h01C, i == 0 ? 32'h0DD0 : 32'h05D0);
            din_in <= i == 0 ? 8'hF7 : 8'hFD;
            repeat (5) @(posedge clk_in);
            rd(12'h018, i == 0 ? 32'h0010 : 32'h0000);
        end
        din_in <= 8'hFF;
        $display("test thermal done");
        for (int i = 0; i < 2; i++)
        begin
            do_reset(16'h0000);
            wr(12'h010, i == 0 ? 32'h0055 : 32'h0064);
            spd_in <= 16'h0258;
            cur_in <= 16'h00A5;
            trip(8, 4 * 57, 4 * 64);
            chk({32'h0, alarm_seen}, {32'h0, i == 0});
            rd(12'h014, 32'h0064);
            cur_in <= 16'h0000;
            repeat (5 * TK) @(posedge clk_in);
            chk({32'h0, ret_out < 16'h0064}, 33'h1);
        end
        do_reset(16'h0028);
        rd(12'h014, 32'h0028);
        do_reset(16'h0000);
        spd_in <= 16'h0258;
        cur_in <= 16'h0069;
        repeat (40 * TK) @(posedge clk_in);
        rd(12'h018, 32'h0000);
        rd(12'h014, 32'h0000);
        spd_in <= 16'h001E;
        repeat (20 * TK) @(posedge clk_in);
        chk({32'h0, ret_out != 16'h0}, 33'h1);
        for (int i = 0; i < 3; i++)
        begin
            do_reset(16'h0000);
            wr(12'h020, 32'h0064);
            if (i == 2) wr(12'h000, 32'h0001);
            cur_in <= i == 1 ? 16'h0095 : 16'h00C8;
            if (i == 0) trip(6, 8, 24);
            else
            begin
                repeat (30 * TK) @(posedge clk_in);
                chk({32'h0, flags_out.power_stage_overload_fault}, 33'h0);
            end
        end
        do_reset(16'h0000);
        wr(12'h004, 32'h00C8);
        wr(12'h008, 32'h00C8);
        wr(12'h00C, 32'h00C8);
        cur_in <= 16'h00C7;
        repeat (80 * TK) @(posedge clk_in);
        chk({32'h0, flags_out.motor_overload_fault}, 33'h0);
        $display("test overload done");
        end_sim;
    end

    // a hang past the expected run length is counted and ends the run
    initial
    begin
        #(40 * 40000);
        n_mismatch++;
        end_sim;
    end
endmodule

bind dps_supervisor dps_supervisor_chk #(.MODULE_FAULT_C(MODULE_FAULT_C)) u_chk (
    .clk_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .prdata_out, .pslverr_out,
    .meas_in, .ground_trip_pin_in, .retained_level_out, .flags_out, .switching_frequency_out);
